// File: rtl/gcmib_regs.sv
`timescale 1ns/100ps
module gcmib_regs import gcmib_pkg::*; (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                soft_rst_i,
  input  wire gcmib_req_t          req_i,
  output logic       [REG_DW-1:0]  reg_rdata_o,
  input  wire logic [CNT_NUM-1:0]  cnt_inc_i,
  input  wire logic                phy_link_i,
  input  wire logic                phy_act_i,
  input  wire logic                phy_speed100_i,
  output logic                     indicator_out_a_o,
  output logic                     indicator_out_b_o,
  input  wire gcmib_evt_t          evt_i,
  input  wire logic                clocks_ready_i,
  output logic                     wake_event_output_o,
  output logic                     auto_wake_en_o,
  output logic                     wake_to_normal_o,
  output logic       [MODE_HI:0]   pwr_mode_o
);

  logic [REG_DW-1:0] chip_global_control;
  logic [REG_DW-1:0] indirect_access_control;
  logic [REG_DW-1:0] indirect_data_low_word;
  logic [REG_DW-1:0] indirect_data_high_word;
  logic [REG_DW-1:0] pwr_ctrl;
  logic [ST_HI:ST_LO] wake_status;
  logic              fetch_pend;
  logic [CNT_DW-1:0] mem_rdata;

  // address decode
  wire wr_global = req_i.wr && (req_i.addr == OFS_GLOBAL);
  wire wr_ind    = req_i.wr && (req_i.addr == OFS_IND_CTRL);
  wire wr_lo     = req_i.wr && (req_i.addr == OFS_DATA_LO);
  wire wr_hi     = req_i.wr && (req_i.addr == OFS_DATA_HI);
  wire wr_pwr    = req_i.wr && (req_i.addr == OFS_PWR_EVT);

  wire tbl_ok    = req_i.wdata[TBL_HI:TBL_LO] == TBL_COUNTERS;
  wire fetch_go  = wr_ind && req_i.wdata[BIT_RD_EN] && tbl_ok;

  wire [3:0] evt_vec  = evt_i;
  wire [3:0] w1c_mask = wr_pwr ? req_i.wdata[ST_HI:ST_LO] : 4'h0;
  // set wins over the write-one clear
  wire [3:0] next_status = (wake_status & ~w1c_mask) | evt_vec;

  wire map_sel   = chip_global_control[BIT_MAP_SEL];
  wire next_led_b = map_sel ? phy_act_i : phy_speed100_i;
  wire next_led_a = map_sel ? phy_link_i
                            : (phy_link_i || phy_act_i);

  wire auto_wk   = pwr_ctrl[BIT_AUTO_WK];
  wire wake_pol  = pwr_ctrl[BIT_POL];
  wire wake_raw  = |(wake_status & pwr_ctrl[EN_HI:EN_LO]);
  wire wake_hold = pwr_ctrl[BIT_DLY_EN] && auto_wk
                   && !clocks_ready_i;
  wire wake_act  = wake_raw && !wake_hold;
  wire next_wake = wake_pol ? wake_act : !wake_act;

  wire [REG_DW-1:0] pwr_rd = {1'b0, pwr_ctrl[14:6], wake_status,
                              pwr_ctrl[MODE_HI:0]};

  // a read right behind a fetch sees the landing word
  wire [REG_DW-1:0] data_lo_rd = fetch_pend ? mem_rdata[15:0]
                                            : indirect_data_low_word;
  wire [REG_DW-1:0] data_hi_rd = fetch_pend ? mem_rdata[31:16]
                                            : indirect_data_high_word;

  logic [REG_DW-1:0] next_rdata;
  always_comb begin
    unique case (req_i.addr)
      OFS_GLOBAL:   next_rdata = chip_global_control;
      OFS_IND_CTRL: next_rdata = indirect_access_control;
      OFS_DATA_LO:  next_rdata = data_lo_rd;
      OFS_DATA_HI:  next_rdata = data_hi_rd;
      OFS_PWR_EVT:  next_rdata = pwr_rd;
      default:      next_rdata = 16'h0000;
    endcase
  end

  gcmib_cnt_mem #(
    .DEPTH (CNT_NUM),
    .AW    (CNT_AW),
    .DW    (CNT_DW)
  ) u_cnt_mem (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .inc_i     (cnt_inc_i),
    .rd_i      (fetch_go),
    .raddr_i   (req_i.wdata[ADDR_HI:0]),
    .rdata_o   (mem_rdata)
  );

  // control registers; soft reset spares the wake status
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chip_global_control     <= RST_GLOBAL;
      indirect_access_control <= RST_IND_CTRL;
      pwr_ctrl                <= RST_PWR_EVT;
    end else if (soft_rst_i) begin
      chip_global_control     <= RST_GLOBAL;
      indirect_access_control <= RST_IND_CTRL;
      pwr_ctrl                <= RST_PWR_EVT;
    end else begin
      if (wr_global) begin
        chip_global_control <= req_i.wdata;
      end
      if (wr_ind) begin
        indirect_access_control <= req_i.wdata;
      end
      if (wr_pwr) begin
        pwr_ctrl <= req_i.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_status <= '0;
    end else begin
      wake_status <= next_status;
    end
  end

  // fetched word lands in both halves in one cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fetch_pend              <= 1'b0;
      indirect_data_low_word  <= RST_DATA;
      indirect_data_high_word <= RST_DATA;
    end else begin
      fetch_pend <= fetch_go;
      if (fetch_pend) begin
        indirect_data_low_word  <= mem_rdata[15:0];
        indirect_data_high_word <= mem_rdata[31:16];
      end else begin
        if (wr_lo) begin
          indirect_data_low_word <= req_i.wdata;
        end
        if (wr_hi) begin
          indirect_data_high_word <= req_i.wdata;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o         <= 16'h0000;
      indicator_out_a_o   <= 1'b0;
      indicator_out_b_o   <= 1'b0;
      wake_event_output_o <= 1'b1;
    end else begin
      if (req_i.rd) begin
        reg_rdata_o <= next_rdata;
      end
      indicator_out_a_o   <= next_led_a;
      indicator_out_b_o   <= next_led_b;
      wake_event_output_o <= next_wake;
    end
  end

  assign auto_wake_en_o   = auto_wk;
  assign wake_to_normal_o = pwr_ctrl[BIT_WK_NORM] && auto_wk;
  assign pwr_mode_o       = pwr_ctrl[MODE_HI:0];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_LED_MAP: assert property (
    1'b1 |=> indicator_out_b_o == ($past(map_sel) ? $past(phy_act_i)
                                                 : $past(phy_speed100_i)))
    else $error("indicator b does not follow map select");

  AST_FETCH_BOTH: assert property (
    fetch_go && !soft_rst_i |-> ##2
    {indirect_data_high_word, indirect_data_low_word} == $past(mem_rdata))
    else $error("data words not loaded from fetched counter");

  AST_NO_FETCH: assert property (
    wr_ind && !req_i.wdata[BIT_RD_EN] ##1 !req_i.wr |=>
    $stable(indirect_data_low_word) && $stable(indirect_data_high_word))
    else $error("data words changed with read enable low");

  AST_TABLE_SEL: assert property (
    wr_ind && !tbl_ok |=> !fetch_pend)
    else $error("fetch started with reserved table code");

  AST_W1C: assert property (
    wr_pwr && evt_vec == 4'h0 |=>
    (wake_status & $past(req_i.wdata[ST_HI:ST_LO])) == 4'h0)
    else $error("status bit not cleared by write one");

  AST_EVT_SET: assert property (
    evt_i.link_up |=> wake_status[ST_LO+1])
    else $error("link-up event not recorded");

  AST_WAKE_HOLD: assert property (
    wake_hold |=> wake_event_output_o == !$past(wake_pol))
    else $error("wake output asserted during delay");

  AST_WAKE_POL: assert property (
    !wake_hold |=> wake_event_output_o ==
    ($past(wake_pol) ? $past(wake_raw) : !$past(wake_raw)))
    else $error("wake output level or polarity wrong");

  AST_RSV_RB: assert property (
    wr_global && !soft_rst_i |=> chip_global_control == $past(req_i.wdata))
    else $error("global control does not read back write");

  AST_LED_A_MAP: assert property (
    1'b1 |=> indicator_out_a_o == ($past(map_sel) ? $past(phy_link_i)
                                  : $past(phy_link_i || phy_act_i)))
    else $error("indicator a does not follow map select");

  AST_READ_BYPASS: assert property (
    req_i.rd && req_i.addr == OFS_DATA_HI && fetch_pend |=>
    reg_rdata_o == $past(mem_rdata[31:16]))
    else $error("read behind a fetch missed the fetched word");

  AST_SOFT_KEEP: assert property (
    soft_rst_i && !wr_pwr |=>
    wake_status == ($past(wake_status) | $past(evt_vec)))
    else $error("soft reset disturbed wake status");

  AST_SOFT_DFLT: assert property (
    soft_rst_i |=> chip_global_control == RST_GLOBAL
                   && pwr_ctrl == RST_PWR_EVT)
    else $error("soft reset missed control defaults");

  AST_ENERGY_WAKE: assert property (
    pwr_ctrl[EN_LO] && wake_status[ST_LO] && !wake_hold |=>
    wake_event_output_o == $past(wake_pol))
    else $error("energy event did not assert wake output");

  AST_CLEAR_IDLE: assert property (
    wake_status == 4'h0 |=> wake_event_output_o == !$past(wake_pol))
    else $error("wake output active with no status");

endmodule : gcmib_regs

// File: rtl/gcmib_pkg.sv
// Notes on behaviour
// - map select 0: b shows 100M speed, a link/act; 1: b activity, a link
// - writing indirect control launches an operation; bit 12 decides a read
// - read enable 1 fetches counter then clears it; 0 does nothing
// - table select 11 picks counters; other codes reserved, host avoids them
// - indirect address bits 4-0 pick one of 32 counters
// - low data word shows counter bits 15-0
// - high data word shows counter bits 31-16
// - delay enable holds wake output inactive until clocks run and access ready
// - wake delay only acts while auto wake-up enable bit 7 is set
// - polarity bit 12: 1 active high, 0 active low wake output
// - enables 11-9 gate wake frame, remote-wake packet, link-up events
// - enable bit 8 gates energy-detect event onto wake output
// - status bits 5-2 clear by power-up reset or write 1; output deasserts
// - auto wake-up enable bit 7 lets energy-detect mode leave low power
package gcmib_pkg;

  localparam int          REG_AW       = 8;
  localparam int          REG_DW       = 16;
  localparam int          CNT_NUM      = 32;
  localparam int          CNT_AW       = 5;
  localparam int          CNT_DW       = 32;

  localparam logic [7:0]  OFS_GLOBAL   = 8'hC6;
  localparam logic [7:0]  OFS_IND_CTRL = 8'hC8;
  localparam logic [7:0]  OFS_DATA_LO  = 8'hD0;
  localparam logic [7:0]  OFS_DATA_HI  = 8'hD2;
  localparam logic [7:0]  OFS_PWR_EVT  = 8'hD4;

  localparam logic [15:0] RST_GLOBAL   = 16'h0835;
  localparam logic [15:0] RST_IND_CTRL = 16'h0000;
  localparam logic [15:0] RST_DATA     = 16'h0000;
  localparam logic [15:0] RST_PWR_EVT  = 16'h0000;

  localparam int          BIT_MAP_SEL  = 9;
  localparam int          BIT_RD_EN    = 12;
  localparam int          TBL_HI       = 11;
  localparam int          TBL_LO       = 10;
  localparam logic [1:0]  TBL_COUNTERS = 2'h3;
  localparam int          ADDR_HI      = 4;
  localparam int          BIT_DLY_EN   = 14;
  localparam int          BIT_RSV_PWR  = 13;
  localparam int          BIT_POL      = 12;
  localparam int          EN_HI        = 11;
  localparam int          EN_LO        = 8;
  localparam int          BIT_AUTO_WK  = 7;
  localparam int          BIT_WK_NORM  = 6;
  localparam int          ST_HI        = 5;
  localparam int          ST_LO        = 2;
  localparam int          MODE_HI      = 1;

  // register port from the serial front end
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [REG_AW-1:0]     addr;
    logic [REG_DW-1:0]     wdata;
  } gcmib_req_t;

  // wake events, one-cycle pulses, ordered as status bits 5..2
  typedef struct packed {
    logic wake_frame;
    logic remote_wake;
    logic link_up;
    logic energy;
  } gcmib_evt_t;

endpackage : gcmib_pkg

// File: rtl/gcmib_cnt_mem.sv
`timescale 1ns/100ps
module gcmib_cnt_mem import gcmib_pkg::*; #(
  parameter int DEPTH = CNT_NUM,
  parameter int AW    = CNT_AW,
  parameter int DW    = CNT_DW
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [DEPTH-1:0] inc_i,
  input  wire logic             rd_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [DW-1:0]    rdata_o
);

  logic [DW-1:0] cnt [DEPTH];

  // a hit in the clear cycle is kept as a count of one
  for (genvar i = 0; i < DEPTH; i++) begin : g_cnt
    wire clr_hit = rd_i && (raddr_i == AW'(i));
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt[i] <= '0;
      end else if (clr_hit) begin
        cnt[i] <= {{(DW-1){1'b0}}, inc_i[i]};
      end else if (inc_i[i]) begin
        cnt[i] <= cnt[i] + {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= cnt[raddr_i];
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_CNT_CLEARED: assert property (
    rd_i && !inc_i[raddr_i] |=> cnt[$past(raddr_i)] == '0)
    else $error("counter not cleared after fetch");

  AST_CNT_FETCH: assert property (
    rd_i |=> rdata_o == $past(cnt[raddr_i]))
    else $error("fetched value differs from addressed counter");

endmodule : gcmib_cnt_mem

// File: test/gcmib_host.sv
`timescale 1ns/100ps
module gcmib_host import gcmib_pkg::*; (
  input  wire logic ref_clk_i,
  output gcmib_req_t req_o
);
  initial req_o = '0;
  // released address and data lines show the inverse of the last value
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
    @(posedge ref_clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : access
endmodule : gcmib_host

// File: test/tb_global_ctrl_mib_indirect_pme.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb_global_ctrl_mib_indirect_pme import gcmib_pkg::*; ;
  logic        ref_clk_i = 0, rst_n_i = 0, soft_rst_i = 0, rdy = 0;
  logic        lnk = 0, act = 0, spd = 0, la, lb, wk, aw, wtn, rd_seen = 0;
  logic [1:0]  pm;
  logic [31:0] cnt_inc_i = '0, rnd = 32'h7828E381;
  logic [15:0] rdata, exp_v, v;
  logic [4:0]  n;
  logic [3:0]  k;
  gcmib_evt_t  evt = '0;
  gcmib_req_t  req;
  logic [15:0] exp_q[$];
  int          fail_count = 0, checks_done = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  gcmib_host u_host (.ref_clk_i(ref_clk_i), .req_o(req));
  gcmib_regs u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .soft_rst_i(soft_rst_i), .req_i(req), .reg_rdata_o(rdata),
    .cnt_inc_i(cnt_inc_i), .phy_link_i(lnk), .phy_act_i(act),
    .phy_speed100_i(spd), .indicator_out_a_o(la), .indicator_out_b_o(lb),
    .evt_i(evt), .clocks_ready_i(rdy), .wake_event_output_o(wk),
    .auto_wake_en_o(aw), .wake_to_normal_o(wtn), .pwr_mode_o(pm));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.access(1'b0, a, 16'h0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d);
  endtask : wr
  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask : settle
  task automatic pulse(input int i);
    @(posedge ref_clk_i);
    evt <= gcmib_evt_t'(4'h1 << i);
    @(posedge ref_clk_i);
    evt <= '0;
    settle(2);
  endtask : pulse
  task automatic complete_run;
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk_i) begin
    if (rd_seen) begin
      exp_v = exp_q.size() ? exp_q.pop_front() : ~rdata;
      `CHK(rdata, exp_v)
    end
    rd_seen <= req.rd;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_GLOBAL, RST_GLOBAL);
    rd(OFS_IND_CTRL, RST_IND_CTRL);
    rd(OFS_DATA_LO, RST_DATA);
    rd(OFS_DATA_HI, RST_DATA);
    rd(OFS_PWR_EVT, RST_PWR_EVT);
    rd(8'hC0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rnd = nxt(rnd);
      v = rnd[15:0];
      v[9] = i[0];
      wr(OFS_GLOBAL, v);
      rd(OFS_GLOBAL, v);
      {lnk, act, spd} <= rnd[18:16];
      settle(2);
      `CHK(la, v[9] ? lnk : (lnk | act))
      `CHK(lb, v[9] ? act : spd)
    end
    for (int j = 0; j < 3; j++) begin
      rnd = nxt(rnd);
      n = rnd[4:0];
      k = {1'b0, rnd[7:5]} + 4'h1;
      wr(OFS_DATA_HI, 16'hFFFF);
      @(posedge ref_clk_i);
      cnt_inc_i <= 32'h1 << n;
      repeat (k) @(posedge ref_clk_i);
      cnt_inc_i <= '0;
      // table 11 only, reserved codes never used
      wr(OFS_IND_CTRL, {3'h0, 1'b1, TBL_COUNTERS, 5'h00, n});
      @(posedge ref_clk_i);
      rd(OFS_DATA_LO, {12'h000, k});
      rd(OFS_DATA_HI, 16'h0000);
      wr(OFS_IND_CTRL, {3'h0, 1'b1, TBL_COUNTERS, 5'h00, n});
      @(posedge ref_clk_i);
      rd(OFS_DATA_LO, 16'h0000);
      wr(OFS_DATA_LO, rnd[31:16]);
      wr(OFS_IND_CTRL, {3'h0, 1'b0, TBL_COUNTERS, 5'h00, n});
      @(posedge ref_clk_i);
      rd(OFS_DATA_LO, rnd[31:16]);
    end
    for (int i = 0; i < 4; i++) begin
      v = 16'h1000 | (16'h0100 << i);
      wr(OFS_PWR_EVT, v);
      pulse(i);
      `CHK(wk, 1'b1)
      rd(OFS_PWR_EVT, v | (16'h0004 << i));
      wr(OFS_PWR_EVT, v | (16'h0004 << i));
      settle(3);
      `CHK(wk, 1'b0)
    end
    wr(OFS_PWR_EVT, 16'h0000);
    pulse(0);
    `CHK(wk, 1'b1)
    wr(OFS_PWR_EVT, 16'h41C1);
    settle(3);
    `CHK(wk, 1'b1)
    `CHK(aw, 1'b1)
    `CHK(wtn, 1'b1)
    `CHK(pm, 2'h1)
    @(posedge ref_clk_i);
    rdy <= 1'b1;
    settle(3);
    `CHK(wk, 1'b0)
    @(posedge ref_clk_i);
    rdy <= 1'b0;
    wr(OFS_PWR_EVT, 16'h4142);
    settle(3);
    `CHK(wk, 1'b0)
    `CHK(aw, 1'b0)
    `CHK(wtn, 1'b0)
    `CHK(pm, 2'h2)
    @(posedge ref_clk_i);
    soft_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    soft_rst_i <= 1'b0;
    rd(OFS_PWR_EVT, 16'h0004);
    rd(OFS_GLOBAL, RST_GLOBAL);
    settle(2);
    complete_run();
  end
endmodule : tb_global_ctrl_mib_indirect_pme
